// >>> common/isf_defines.svh
`ifndef ISF_DEFINES_SVH
`define ISF_DEFINES_SVH
// ==========================================================
// register offsets and reset values
`define ISF_OFS_FILTER   8'hdb
`define ISF_OFS_DATA     8'hde
`define ISF_OFS_OWNID    8'hdf
`define ISF_RST_BYTE     8'h00
// ==========================================================
// field positions
`define ISF_FILT_EN_BIT  7
`define ISF_FILT_CNT_HI  6
`define ISF_OWN_HI       7
`define ISF_OWN_LO       1
`define ISF_MSB          7
// ==========================================================
// counts
`define ISF_BITS_BYTE    4'h8
`define ISF_BIT_ZERO     4'h0
`define ISF_BIT_ONE      4'h1
`define ISF_ONE_SAMPLE   8'h01
`define ISF_TICK_ONE     11'h001
// ==========================================================
// half periods of the bit clock in core clocks, per divisor select
`define ISF_HALF_DIV0    11'h010
`define ISF_HALF_DIV1    11'h018
`define ISF_HALF_DIV2    11'h01e
`define ISF_HALF_DIV3    11'h03c
`define ISF_HALF_DIV4    11'h078
`define ISF_HALF_DIV5    11'h0f0
`define ISF_HALF_DIV6    11'h1e0
`define ISF_HALF_DIV7    11'h3c0
`endif

// >>> common/isf_pkg.sv
package isf_pkg;
  typedef logic [7:0] isf_byte_type;
  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_FILT   = 7'h02,
    ST_MSTART = 7'h04,
    ST_SHIFT  = 7'h08,
    ST_ACK    = 7'h10,
    ST_STALL  = 7'h20,
    ST_MSTOP  = 7'h40
  } isf_state_type;
endpackage

// >>> rtl/isf_byte_buffer.sv
`timescale 1ns/1ns
`default_nettype none
module isf_byte_buffer (
  // clock and reset
  input  wire logic           clk,
  input  wire logic           reset,
  // fill side
  input  wire logic           in_valid,
  output logic                in_ready,
  input  wire isf_pkg::isf_byte_type in_data,
  // drain side
  output logic                out_valid,
  input  wire logic           out_ready,
  output isf_pkg::isf_byte_type out_data
);
  import isf_pkg::*;
  isf_byte_type mem [2];
  isf_byte_type next_mem [2];
  logic         wr_ptr;
  logic         rd_ptr;
  logic [1:0]   count;
  logic         next_wr_ptr;
  logic         next_rd_ptr;
  logic [1:0]   next_count;
  logic         push;
  logic         pop;

  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    next_mem    = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push) begin
      next_mem[wr_ptr] = in_data;
      next_wr_ptr      = ~wr_ptr;
    end
    if (pop) begin
      next_rd_ptr = ~rd_ptr;
    end
    if (push && !pop) begin
      next_count = count + 2'h1;
    end else if (pop && !push) begin
      next_count = count - 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mem[0] <= 8'h00;
      mem[1] <= 8'h00;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      mem    <= next_mem;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/isf_engine.sv
`timescale 1ns/1ns
`default_nettype none
`include "isf_defines.svh"
module isf_engine (
  // clock and reset
  input  wire logic           clk,
  input  wire logic           reset,
  // special function register port
  input  wire logic [7:0]     sfr_addr,
  input  wire logic           sfr_wr,
  input  wire logic           sfr_rd,
  input  wire isf_pkg::isf_byte_type sfr_wdata,
  output isf_pkg::isf_byte_type sfr_rdata,
  // control bits
  input  wire logic           interface_enable,
  input  wire logic           begin_condition_request,
  input  wire logic           end_condition_request,
  input  wire logic           ack_enable,
  input  wire logic [2:0]     clock_divisor_select,
  input  wire logic           clear_byte_event,
  input  wire logic           clear_own_match,
  // status bits
  output logic                byte_event_flag,
  output logic                own_match_flag,
  output logic                line_occupied_flag,
  output logic                tx_mode_flag,
  output logic                master_flag,
  output logic                ack_resp_flag,
  output logic                begin_request_done,
  output logic                end_request_done,
  // bus lines
  input  wire logic           scl_in,
  output logic                scl_out,
  output logic                scl_oe,
  input  wire logic           sda_in,
  output logic                sda_out,
  output logic                sda_oe
);
  import isf_pkg::*;

  // ==========================================================
  // half bit period for the selected divisor
  function automatic logic [10:0] half_div(input logic [2:0] sel);
    case (sel)
      3'h0:    half_div = `ISF_HALF_DIV0;
      3'h1:    half_div = `ISF_HALF_DIV1;
      3'h2:    half_div = `ISF_HALF_DIV2;
      3'h3:    half_div = `ISF_HALF_DIV3;
      3'h4:    half_div = `ISF_HALF_DIV4;
      3'h5:    half_div = `ISF_HALF_DIV5;
      3'h6:    half_div = `ISF_HALF_DIV6;
      default: half_div = `ISF_HALF_DIV7;
    endcase
  endfunction

  // ==========================================================
  // state
  isf_state_type state, next_state;
  isf_byte_type  begin_filter_reg, next_begin_filter_reg;
  isf_byte_type  own_id_reg, next_own_id_reg;
  isf_byte_type  serial_shift_reg, next_serial_shift_reg;
  isf_byte_type  next_sfr_rdata;
  logic [7:0]    samp, next_samp;
  logic [3:0]    bit_cnt, next_bit_cnt;
  logic [10:0]   tick_cnt, next_tick_cnt;
  logic          addr_phase, next_addr_phase;
  logic          phase, next_phase;
  logic          drv_sda, next_drv_sda;
  logic          m_scl_low, next_m_scl_low;
  logic          pend_push, next_pend_push;
  logic          next_byte_event, next_own_match, next_busy;
  logic          next_tx_mode, next_master, next_ack_resp;
  logic          next_begin_done, next_end_done;
  logic          scl_s1, scl_s2, scl_p, sda_s1, sda_s2, sda_p;
  logic          scl_rise, scl_fall, start_seen, stop_seen, tick;
  logic          wr_data, rd_data, own_match_now, push_rx;
  logic          buf_in_ready, buf_out_valid;
  isf_byte_type  buf_out_data;

  // ==========================================================
  // line events, seen only from the second synchroniser stage
  assign scl_rise   = scl_s2 & ~scl_p;
  assign scl_fall   = ~scl_s2 & scl_p;
  assign start_seen = scl_s2 & scl_p & sda_p & ~sda_s2;
  assign stop_seen  = scl_s2 & scl_p & ~sda_p & sda_s2;
  assign tick       = (tick_cnt == 11'h000);
  assign wr_data    = sfr_wr && (sfr_addr == `ISF_OFS_DATA);
  assign rd_data    = sfr_rd && (sfr_addr == `ISF_OFS_DATA);
  assign own_match_now = (serial_shift_reg[`ISF_OWN_HI:`ISF_OWN_LO]
                          == own_id_reg[`ISF_OWN_HI:`ISF_OWN_LO]);
  assign push_rx    = addr_phase ? ~master_flag : ~tx_mode_flag;

  // ==========================================================
  // line drivers: open drain, only ever pull low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe  = interface_enable & ((state == ST_STALL) | m_scl_low);
  assign sda_oe  = interface_enable & drv_sda;

  // ==========================================================
  // received bytes wait here until firmware reads them
  isf_byte_buffer u_rx_buffer (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (pend_push),
    .in_ready  (buf_in_ready),
    .in_data   (serial_shift_reg),
    .out_valid (buf_out_valid),
    .out_ready (rd_data),
    .out_data  (buf_out_data)
  );

  // ==========================================================
  // next values
  always_comb begin
    next_state            = state;
    next_begin_filter_reg = begin_filter_reg;
    next_own_id_reg       = own_id_reg;
    next_serial_shift_reg = serial_shift_reg;
    next_sfr_rdata        = sfr_rdata;
    next_samp             = samp;
    next_bit_cnt          = bit_cnt;
    next_addr_phase       = addr_phase;
    next_phase            = phase;
    next_drv_sda          = drv_sda;
    next_m_scl_low        = m_scl_low;
    next_pend_push        = pend_push;
    next_tx_mode          = tx_mode_flag;
    next_master           = master_flag;
    next_ack_resp         = ack_resp_flag;
    next_begin_done       = 1'b0;
    next_end_done         = 1'b0;
    next_tick_cnt = tick ? half_div(clock_divisor_select) - `ISF_TICK_ONE
                         : tick_cnt - `ISF_TICK_ONE;
    next_busy = line_occupied_flag;
    if (start_seen) begin
      next_busy = 1'b1;
    end else if (stop_seen) begin
      next_busy = 1'b0;
    end
    // firmware clears, a same-cycle set below wins
    next_byte_event = clear_byte_event ? 1'b0 : byte_event_flag;
    next_own_match  = clear_own_match ? 1'b0 : own_match_flag;
    // register port
    if (sfr_wr && sfr_addr == `ISF_OFS_FILTER) begin
      next_begin_filter_reg = sfr_wdata;
    end else if (sfr_wr && sfr_addr == `ISF_OFS_OWNID) begin
      next_own_id_reg = sfr_wdata;
    end
    if (sfr_rd) begin
      if (sfr_addr == `ISF_OFS_FILTER) begin
        next_sfr_rdata = begin_filter_reg;
      end else if (sfr_addr == `ISF_OFS_DATA) begin
        next_sfr_rdata = buf_out_valid ? buf_out_data : serial_shift_reg;
      end else if (sfr_addr == `ISF_OFS_OWNID) begin
        next_sfr_rdata = own_id_reg;
      end else begin
        next_sfr_rdata = `ISF_RST_BYTE;
      end
    end
    // master clock: release on a tick, pull low a half period after high
    if (master_flag && tick && (state == ST_SHIFT || state == ST_ACK)) begin
      if (m_scl_low) begin
        next_m_scl_low = 1'b0;
      end else if (scl_s2) begin
        next_m_scl_low = 1'b1;
      end
    end
    case (state)
      ST_IDLE: begin
        next_drv_sda   = 1'b0;
        next_m_scl_low = 1'b0;
        next_master    = 1'b0;
        if (wr_data) begin
          next_serial_shift_reg = sfr_wdata;
        end
        if (begin_condition_request && !line_occupied_flag) begin
          next_state = ST_MSTART;
          next_phase = 1'b0;
        end else if (start_seen) begin
          next_state = ST_FILT;
          next_samp  = begin_filter_reg[`ISF_FILT_EN_BIT]
                     ? {1'b0, begin_filter_reg[`ISF_FILT_CNT_HI:0]} + `ISF_ONE_SAMPLE
                     : `ISF_ONE_SAMPLE;
        end
      end
      ST_FILT: begin
        // one sample per core clock
        if (!sda_s2 && scl_s2) begin
          if (samp == `ISF_ONE_SAMPLE) begin
            next_state      = ST_SHIFT;
            next_bit_cnt    = `ISF_BIT_ZERO;
            next_addr_phase = 1'b1;
            next_tx_mode    = 1'b0;
          end else begin
            next_samp = samp - `ISF_ONE_SAMPLE;
          end
        end else begin
          next_state = ST_IDLE;
        end
      end
      ST_MSTART: begin
        next_drv_sda = 1'b1;
        if (tick) begin
          if (!phase) begin
            next_phase = 1'b1;
          end else begin
            next_m_scl_low  = 1'b1;
            next_state      = ST_SHIFT;
            next_master     = 1'b1;
            next_tx_mode    = 1'b1;
            next_addr_phase = 1'b1;
            next_bit_cnt    = `ISF_BIT_ZERO;
            next_begin_done = 1'b1;
          end
        end
      end
      ST_SHIFT: begin
        if (scl_rise) begin
          next_serial_shift_reg = {serial_shift_reg[6:0], sda_s2};
          next_bit_cnt          = bit_cnt + `ISF_BIT_ONE;
        end else if (scl_fall) begin
          if (bit_cnt == `ISF_BITS_BYTE) begin
            next_state   = ST_ACK;
            next_drv_sda = push_rx & ack_enable;
            if (addr_phase && !master_flag) begin
              if (own_match_now) begin
                next_own_match  = 1'b1;
                next_byte_event = 1'b1;
              end else begin
                next_state   = ST_IDLE;
                next_drv_sda = 1'b0;
              end
            end
          end else begin
            next_drv_sda = tx_mode_flag & ~serial_shift_reg[`ISF_MSB];
          end
        end
      end
      ST_ACK: begin
        if (scl_rise) begin
          next_ack_resp = sda_s2;
        end else if (scl_fall) begin
          next_state      = ST_STALL;
          next_drv_sda    = 1'b0;
          next_byte_event = 1'b1;
          next_pend_push  = push_rx & ~(addr_phase & serial_shift_reg[0]);
          next_addr_phase = 1'b0;
          if (addr_phase) begin
            next_tx_mode = master_flag ? ~serial_shift_reg[0]
                                       : serial_shift_reg[0];
          end
        end
      end
      ST_STALL: begin
        if (pend_push && buf_in_ready) begin
          next_pend_push = 1'b0;
        end
        if (!pend_push && ((tx_mode_flag && wr_data) ||
                           (!tx_mode_flag && rd_data))) begin
          if (wr_data) begin
            next_serial_shift_reg = sfr_wdata;
          end
          next_bit_cnt = `ISF_BIT_ZERO;
          if (master_flag && end_condition_request) begin
            next_state   = ST_MSTOP;
            next_phase   = 1'b0;
            next_drv_sda = 1'b1;
          end else begin
            next_state   = ST_SHIFT;
            next_drv_sda = tx_mode_flag & ~sfr_wdata[`ISF_MSB];
          end
        end
      end
      ST_MSTOP: begin
        if (tick) begin
          if (!phase) begin
            next_m_scl_low = 1'b0;
            next_phase     = 1'b1;
          end else if (scl_s2) begin
            next_drv_sda   = 1'b0;
            next_state     = ST_IDLE;
            next_master    = 1'b0;
            next_end_done  = 1'b1;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // a stop on the line ends any slave transfer
    if (stop_seen && !master_flag && state != ST_IDLE) begin
      next_state   = ST_IDLE;
      next_drv_sda = 1'b0;
    end
    if (!interface_enable) begin
      next_state     = ST_IDLE;
      next_drv_sda   = 1'b0;
      next_m_scl_low = 1'b0;
      next_master    = 1'b0;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk) begin
    scl_s1 <= scl_in;
    scl_s2 <= scl_s1;
    scl_p  <= scl_s2;
    sda_s1 <= sda_in;
    sda_s2 <= sda_s1;
    sda_p  <= sda_s2;
    if (reset) begin
      state              <= ST_IDLE;
      begin_filter_reg   <= `ISF_RST_BYTE;
      own_id_reg         <= `ISF_RST_BYTE;
      serial_shift_reg   <= `ISF_RST_BYTE;
      sfr_rdata          <= `ISF_RST_BYTE;
      samp               <= 8'h00;
      bit_cnt            <= 4'h0;
      tick_cnt           <= 11'h000;
      addr_phase         <= 1'b0;
      phase              <= 1'b0;
      drv_sda            <= 1'b0;
      m_scl_low          <= 1'b0;
      pend_push          <= 1'b0;
      byte_event_flag    <= 1'b0;
      own_match_flag     <= 1'b0;
      line_occupied_flag <= 1'b0;
      tx_mode_flag       <= 1'b0;
      master_flag        <= 1'b0;
      ack_resp_flag      <= 1'b0;
      begin_request_done <= 1'b0;
      end_request_done   <= 1'b0;
    end else begin
      state              <= next_state;
      begin_filter_reg   <= next_begin_filter_reg;
      own_id_reg         <= next_own_id_reg;
      serial_shift_reg   <= next_serial_shift_reg;
      sfr_rdata          <= next_sfr_rdata;
      samp               <= next_samp;
      bit_cnt            <= next_bit_cnt;
      tick_cnt           <= next_tick_cnt;
      addr_phase         <= next_addr_phase;
      phase              <= next_phase;
      drv_sda            <= next_drv_sda;
      m_scl_low          <= next_m_scl_low;
      pend_push          <= next_pend_push;
      byte_event_flag    <= next_byte_event;
      own_match_flag     <= next_own_match;
      line_occupied_flag <= next_busy;
      tx_mode_flag       <= next_tx_mode;
      master_flag        <= next_master;
      ack_resp_flag      <= next_ack_resp;
      begin_request_done <= next_begin_done;
      end_request_done   <= next_end_done;
    end
  end
endmodule
`default_nettype wire

// >>> tb/isf_bus_partner.sv
`timescale 1ns/1ns
`default_nettype none
module isf_bus_partner #(
  parameter int HALF = 200
) (
  // line levels
  input  wire logic scl_line,
  input  wire logic sda_line,
  // open-drain pulls, high pulls low
  output var logic  scl_low,
  output var logic  sda_low
);
  // ==========================================
  // far-side bus master
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // width above zero gives a short data dip instead
  task automatic start(input int hold, input int width);
    #7 sda_low = 1'b1;
    if (width > 0) begin
      #width sda_low = 1'b0;
      #HALF;
    end
    else #hold;
    scl_low = 1'b1;
    #HALF;
  endtask
  // high phase, waits out a stretched clock
  task automatic clock_pulse;
    #(HALF * 3 / 4) scl_low = 1'b0;
    wait (scl_line);
  endtask
  task automatic bit_out(input logic b);
    #(HALF / 4) sda_low = !b;
    clock_pulse;
    #HALF scl_low = 1'b1;
  endtask
  task automatic bit_in(output logic b);
    #(HALF / 4) sda_low = 1'b0;
    clock_pulse;
    #(HALF * 3 / 4) b = sda_line;
    #(HALF / 4) scl_low = 1'b1;
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(ack);
  endtask
  task automatic get_byte(output logic [7:0] d, input logic nack);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(nack);
  endtask
  task automatic stop;
    #(HALF / 4) sda_low = 1'b1;
    clock_pulse;
    #HALF sda_low = 1'b0;
    #HALF;
  endtask
endmodule
`default_nettype wire

// >>> tb/isf_engine_assertions.sv
`timescale 1ns/1ns
`default_nettype none
`include "isf_defines.svh"
module isf_engine_assertions (
  // clock and reset
  input wire logic       clk,
  input wire logic       reset,
  // register port
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  // control
  input wire logic       interface_enable,
  input wire logic       clear_byte_event,
  input wire logic       clear_own_match,
  // status and bus drives
  input wire logic       byte_event_flag,
  input wire logic       own_match_flag,
  input wire logic       line_occupied_flag,
  input wire logic       tx_mode_flag,
  input wire logic       master_flag,
  input wire logic       scl_oe,
  input wire logic       sda_oe
);
  // ==========================================
  // properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  logic data_hit;
  assign data_hit = (sfr_rd || sfr_wr) && sfr_addr == `ISF_OFS_DATA;
  AST_DISABLED_RELEASE: assert property (!interface_enable [*2] |-> !scl_oe && !sda_oe)
    else $error("line pulled while disabled");
  AST_EVENT_STICKY: assert property (byte_event_flag && !clear_byte_event |=> byte_event_flag)
    else $error("byte event dropped without clear");
  AST_MATCH_STICKY: assert property (own_match_flag && !clear_own_match |=> own_match_flag)
    else $error("match flag dropped without clear");
  AST_MATCH_EVENT: assert property ($rose(own_match_flag) |-> ##[0:40] byte_event_flag)
    else $error("match without byte event");
  AST_STALL: assert property ($rose(byte_event_flag) && !$rose(own_match_flag)
    && !master_flag |-> ##[0:4] scl_oe) else $error("no clock stall after byte");
  AST_HOLD: assert property (scl_oe && !master_flag && !data_hit |=> scl_oe)
    else $error("stall released without data access");
  AST_RX_RELEASE: assert property (scl_oe && !master_flag && !tx_mode_flag && sfr_rd
    && sfr_addr == `ISF_OFS_DATA |-> ##[1:4] !scl_oe) else $error("read kept stall");
  AST_TX_RELEASE: assert property (scl_oe && !master_flag && tx_mode_flag && sfr_wr
    && sfr_addr == `ISF_OFS_DATA |-> ##[1:4] !scl_oe) else $error("write kept stall");
  AST_MATCH_SLAVE: assert property ($rose(own_match_flag) |-> line_occupied_flag
    && !master_flag) else $error("match outside slave transfer");
  cover property ($rose(own_match_flag));
  cover property (scl_oe && tx_mode_flag);
  cover property (scl_oe && !tx_mode_flag);
endmodule
bind isf_engine isf_engine_assertions chk_u (
  .clk, .reset, .sfr_addr, .sfr_wr, .sfr_rd, .interface_enable, .clear_byte_event,
  .clear_own_match, .byte_event_flag, .own_match_flag, .line_occupied_flag,
  .tx_mode_flag, .master_flag, .scl_oe, .sda_oe
);
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "isf_defines.svh"
module tb_top;
  import isf_pkg::*;
  // ==========================================
  // signals
  logic         clk = 1'b0;
  logic         reset = 1'b1;
  logic [7:0]   sfr_addr = 8'h00;
  logic         sfr_wr = 1'b0;
  logic         sfr_rd = 1'b0;
  isf_byte_type sfr_wdata = 8'h00;
  isf_byte_type sfr_rdata;
  logic         interface_enable = 1'b1;
  logic         ack_enable = 1'b0;
  logic         clear_byte_event = 1'b0;
  logic         clear_own_match = 1'b0;
  logic         byte_event_flag;
  logic         own_match_flag;
  logic         scl_oe;
  logic         sda_oe;
  logic         m_scl_low;
  logic         m_sda_low;
  logic         begin_condition_request = 1'b0;
  logic         end_condition_request = 1'b0;
  logic         line_occupied_flag;
  logic         tx_mode_flag;
  logic         master_flag;
  logic         ack_resp_flag;
  logic         begin_request_done;
  logic         end_request_done;
  logic [8:0]   line_bits = 9'h000;
  int           n_errors = 0;
  int           checks_done = 0;
  int           cycles = 0;
  wire logic    scl_line = !(scl_oe || m_scl_low);
  wire logic    sda_line = !(sda_oe || m_sda_low);
  localparam logic [7:0] OFS [4] = '{8'hdb, 8'hde, 8'hdf, 8'hdc};
  localparam logic [7:0] FLTS [4] = '{8'h00, 8'h80, 8'h85, 8'hff};
  always #25 clk = ~clk;
  isf_engine dut_u (
    .clk, .reset, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
    .interface_enable, .begin_condition_request, .end_condition_request,
    .ack_enable, .clock_divisor_select(3'h0), .clear_byte_event, .clear_own_match,
    .byte_event_flag, .own_match_flag, .line_occupied_flag, .tx_mode_flag,
    .master_flag, .ack_resp_flag, .begin_request_done, .end_request_done,
    .scl_in(scl_line), .scl_out(), .scl_oe, .sda_in(sda_line), .sda_out(), .sda_oe
  );
  isf_bus_partner bm_u (.scl_line, .sda_line, .scl_low(m_scl_low), .sda_low(m_sda_low));
  // line bits as any listener sees them on the clock rise
  always @(posedge scl_line) line_bits <= {line_bits[7:0], sda_line};
  // ==========================================
  // helpers
  task automatic tick;
    @(posedge clk);
    #5;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    tick;
    sfr_wr = 1'b0;
    tick;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    sfr_addr = a;
    sfr_rd = 1'b1;
    tick;
    sfr_rd = 1'b0;
    v = sfr_rdata;
    tick;
  endtask
  function automatic int samples(input logic [7:0] f);
    return f[7] ? int'(f[6:0]) + 1 : 1;
  endfunction
  // firmware side: wait for event, release the stall, clear flags
  task automatic serve(input logic tx, input logic [7:0] wv, input logic m,
                       output logic [7:0] v);
    int k;
    for (k = 0; k < 4000 && byte_event_flag !== 1'b1; k++) tick;
    repeat (20) tick;
    chk("clock stall", 8'h00, 8'(scl_line));
    chk("match flag", 8'(m), 8'(own_match_flag));
    if (tx) wr(`ISF_OFS_DATA, wv);
    else rd(`ISF_OFS_DATA, v);
    clear_byte_event = 1'b1;
    clear_own_match = 1'b1;
    tick;
    clear_byte_event = 1'b0;
    clear_own_match = 1'b0;
  endtask
  task automatic slave(input logic [7:0] a, input logic [7:0] d, input int hold);
    logic       ack;
    logic [7:0] got;
    logic [7:0] got2;
    if (a[0]) wr(`ISF_OFS_DATA, d);
    bm_u.start(hold, 0);
    fork
      bm_u.put_byte(a, ack);
      serve(a[0], d, 1'b1, got);
    join
    chk("address ack", 8'h00, 8'(ack));
    if (!a[0]) chk("address byte", a, got);
    fork
      if (a[0]) bm_u.get_byte(got, 1'b1);
      else bm_u.put_byte(d, ack);
      serve(a[0], 8'hff, 1'b0, got2);
    join
    chk("data byte", d, a[0] ? got : got2);
    bm_u.stop;
  endtask
  task automatic probe(input logic [7:0] a, input int width, input int hold);
    logic ack;
    bm_u.start(hold, width);
    bm_u.put_byte(a, ack);
    chk("refused ack", 8'h01, 8'(ack));
    chk("refused match", 8'h00, 8'(own_match_flag));
    bm_u.stop;
  endtask
  // engine as master, no slave answers, so the address is not acknowledged
  task automatic master(input logic [7:0] a);
    int         k;
    logic [7:0] got;
    ack_enable = 1'b0;
    wr(`ISF_OFS_DATA, a);
    begin_condition_request = 1'b1;
    for (k = 0; k < 400 && begin_request_done !== 1'b1; k++) tick;
    begin_condition_request = 1'b0;
    chk("begin done", 8'h01, 8'(begin_request_done));
    for (k = 0; k < 4000 && byte_event_flag !== 1'b1; k++) tick;
    chk("master address", a, line_bits[8:1]);
    chk("master stall", 8'h00, 8'(scl_line));
    chk("master nack", 8'h01, 8'(ack_resp_flag));
    chk("master mode", {6'h00, ~a[0], 1'b1}, {6'h00, tx_mode_flag, master_flag});
    end_condition_request = 1'b1;
    if (a[0]) rd(`ISF_OFS_DATA, got);
    else wr(`ISF_OFS_DATA, 8'h00);
    for (k = 0; k < 400 && end_request_done !== 1'b1; k++) tick;
    end_condition_request = 1'b0;
    chk("end done", 8'h01, 8'(end_request_done));
    clear_byte_event = 1'b1;
    repeat (4) tick;
    clear_byte_event = 1'b0;
    chk("bus free", 8'h00, {6'h00, line_occupied_flag, master_flag});
  endtask
  task automatic test_done;
    if (n_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ==========================================
  // sequence
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      test_done;
    end
  end
  initial begin
    logic [7:0] got;
    logic [7:0] own;
    logic [7:0] dv;
    logic [7:0] flt;
    logic [6:0] id;
    int         hold;
    void'($urandom(14612));
    repeat (20) tick;
    reset = 1'b0;
    tick;
    for (int i = 0; i < 4; i++) begin
      rd(OFS[i], got);
      chk("reset value", 8'h00, got);
    end
    wr(8'hdc, 8'h5a);
    rd(8'hdc, got);
    chk("unmapped read", 8'h00, got);
    for (int r = 0; r < 8; r++) begin
      id = (r == 0) ? 7'h7f : 7'($urandom);
      dv = (r < 2) ? {r[0], 7'h00} : 8'($urandom);
      flt = FLTS[r % 4];
      own = {id, 1'($urandom)};
      hold = samples(flt) * 50 + 300;
      wr(`ISF_OFS_FILTER, flt);
      rd(`ISF_OFS_FILTER, got);
      chk("filter setup", flt, got);
      wr(`ISF_OFS_OWNID, own);
      ack_enable = 1'b1;
      slave({id, 1'b0}, dv, hold);
      slave({id, 1'b1}, ~dv, hold);
      probe({id ^ 7'h01, 1'b0}, 0, hold);
    end
    master({id, 1'b0});
    master({id, 1'b1});
    wr(`ISF_OFS_FILTER, 8'h85);
    probe({id, 1'b0}, 100, 0);
    interface_enable = 1'b0;
    probe({id, 1'b0}, 0, 600);
    interface_enable = 1'b1;
    rd(`ISF_OFS_OWNID, got);
    chk("own id kept", own, got);
    test_done;
  end
endmodule
`default_nettype wire
